// [verilog/sacs_sequencer.sv]
// Conversion control logic for a 16-bit successive-approximation converter
`timescale 1ns/100ps
module sacs_sequencer (
    input  wire logic        clk_in,             // 25 MHz clock
    input  wire logic        rst_n_in,           // Synchronous reset, active low
    input  wire logic        convert_start_in,   // Convert pin from host
    input  wire logic        comp_high_in,       // Comparator: input above trial level
    input  wire logic        over_range_in,      // Input above positive full scale
    input  wire logic        under_range_in,     // Input below negative full scale
    output logic             pos_sample_switch_out, // Plus comparator switch closed
    output logic             neg_sample_switch_out, // Minus comparator switch closed
    output logic             array_to_input_out, // Arrays tied to inputs (else ground)
    output logic [15:0]      dac_trial_out,      // Capacitor switch settings, 1 = REF
    output logic             powered_up_out,     // Analog core powered
    output logic             busy_out,           // Conversion in progress
    output logic             result_valid_out,   // One-cycle end-of-conversion pulse
    output logic [15:0]      result_out          // Two's-complement result
);
    sacs_pkg::sacs_state_type state_reg;          // Sequencer state
    logic        cnv_meta_reg;                    // First synchroniser stage
    logic        cnv_sync_reg;                    // Second synchroniser stage
    logic        cnv_prev_reg;                    // Previous synchronised level
    logic        cnv_rise;                        // Rising edge seen
    logic [3:0]  bit_reg;                         // Bit being decided
    logic [3:0]  wait_reg;                        // Settle counter
    logic [3:0]  div_reg;                         // Conversion clock divider
    logic        conv_tick;                       // Conversion clock enable
    logic [15:0] trial_reg;                       // Successive approximation word
    logic        sat_hi_reg;                      // Over-range latched
    logic        sat_lo_reg;                      // Under-range latched

    // Synchronise the convert pin
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnv_meta_reg <= 1'b0;
            cnv_sync_reg <= 1'b0;
            cnv_prev_reg <= 1'b0;
        end else begin
            cnv_meta_reg <= convert_start_in;
            cnv_sync_reg <= cnv_meta_reg;
            cnv_prev_reg <= cnv_sync_reg;
        end
    end

    // Rising edge of the synchronised convert level
    assign cnv_rise = cnv_sync_reg && !cnv_prev_reg;

    // Internal conversion clock, runs only while deciding
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || state_reg != sacs_pkg::ST_DECIDE) begin
            div_reg <= 4'h0;
        end else if (div_reg == sacs_pkg::CONV_DIV) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end
    assign conv_tick = (state_reg == sacs_pkg::ST_DECIDE) && (div_reg == sacs_pkg::CONV_DIV);

    // Sequencer state and bit counter
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_reg <= sacs_pkg::ST_ACQ;
            bit_reg   <= sacs_pkg::MSB_INDEX;
            wait_reg  <= 4'h0;
        end else begin
            unique case (state_reg)
                sacs_pkg::ST_ACQ: begin
                    if (cnv_rise) begin
                        state_reg <= sacs_pkg::ST_OPEN_SW;
                        wait_reg  <= sacs_pkg::SETTLE_CYC;
                    end
                end
                sacs_pkg::ST_OPEN_SW: begin      // Edges ignored from here
                    if (wait_reg == 4'h1) begin
                        state_reg <= sacs_pkg::ST_GROUND;
                        wait_reg  <= sacs_pkg::SETTLE_CYC;
                    end else begin
                        wait_reg <= wait_reg - 4'h1;
                    end
                end
                sacs_pkg::ST_GROUND: begin
                    if (wait_reg == 4'h1) begin
                        state_reg <= sacs_pkg::ST_DECIDE;
                        bit_reg   <= sacs_pkg::MSB_INDEX;
                    end else begin
                        wait_reg <= wait_reg - 4'h1;
                    end
                end
                sacs_pkg::ST_DECIDE: begin
                    if (conv_tick) begin
                        if (bit_reg == 4'h0) begin
                            state_reg <= sacs_pkg::ST_DONE;
                        end else begin
                            bit_reg <= bit_reg - 4'h1;
                        end
                    end
                end
                sacs_pkg::ST_DONE: begin
                    state_reg <= sacs_pkg::ST_ACQ;
                end
                default: begin
                    state_reg <= sacs_pkg::ST_ACQ;
                end
            endcase
        end
    end

    // Trial word: keep or drop the bit under test, then try the next one
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            trial_reg <= 16'h0000;
        end else if (state_reg == sacs_pkg::ST_GROUND && wait_reg == 4'h1) begin
            trial_reg <= 16'h8000;               // Half-reference step first
        end else if (conv_tick) begin
            trial_reg[bit_reg] <= comp_high_in;
            if (bit_reg != 4'h0) begin
                trial_reg[bit_reg - 4'h1] <= 1'b1;
            end
        end
    end

    // Range detectors latched while the sample is held
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sat_hi_reg <= 1'b0;
            sat_lo_reg <= 1'b0;
        end else if (state_reg == sacs_pkg::ST_GROUND && wait_reg == 4'h1) begin
            sat_hi_reg <= over_range_in;
            sat_lo_reg <= under_range_in;
        end
    end

    // Analog switch and power outputs
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pos_sample_switch_out <= 1'b1;
            neg_sample_switch_out <= 1'b1;
            array_to_input_out    <= 1'b1;
            powered_up_out        <= 1'b0;
            dac_trial_out         <= 16'h0000;
            busy_out              <= 1'b0;
        end else begin
            pos_sample_switch_out <= (state_reg == sacs_pkg::ST_ACQ) && !cnv_rise;
            neg_sample_switch_out <= (state_reg == sacs_pkg::ST_ACQ) && !cnv_rise;
            array_to_input_out    <= (state_reg == sacs_pkg::ST_ACQ)
                                     || (state_reg == sacs_pkg::ST_OPEN_SW);
            powered_up_out        <= (state_reg != sacs_pkg::ST_ACQ)
                                     && (state_reg != sacs_pkg::ST_DONE);
            dac_trial_out         <= trial_reg;
            busy_out              <= (state_reg != sacs_pkg::ST_ACQ)
                                     && (state_reg != sacs_pkg::ST_DONE);
        end
    end

    // Output code: MSB inverted gives two's complement, range clamps win
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            result_out       <= sacs_pkg::CODE_ZERO;
            result_valid_out <= 1'b0;
        end else begin
            result_valid_out <= (state_reg == sacs_pkg::ST_DONE);
            if (state_reg == sacs_pkg::ST_DONE) begin
                if (sat_hi_reg) begin
                    result_out <= sacs_pkg::CODE_MAX;
                end else if (sat_lo_reg) begin
                    result_out <= sacs_pkg::CODE_MIN;
                end else begin
                    result_out <= {~trial_reg[15], trial_reg[14:0]};
                end
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_open;
        !pos_sample_switch_out && array_to_input_out;
    endsequence
    sequence s_ground;
        !pos_sample_switch_out && !array_to_input_out;
    endsequence

    start_on_edge_a: assert property (state_reg == sacs_pkg::ST_ACQ && cnv_rise
        |=> state_reg == sacs_pkg::ST_OPEN_SW) else $error("Edge did not start");
    // Switches open, arrays stay on inputs through the settle cycle, then ground
    switch_order_a: assert property ($fell(pos_sample_switch_out)
        |-> s_open ##1 s_open ##1 s_ground) else $error("Arrays grounded early");
    ground_then_open_a: assert property (s_ground |-> !neg_sample_switch_out)
        else $error("Switch closed while grounded");
    bit_order_a: assert property (conv_tick && bit_reg != 4'h0
        |=> bit_reg == $past(bit_reg) - 4'h1) else $error("Bit order broken");
    done_return_a: assert property (state_reg == sacs_pkg::ST_DONE
        |=> state_reg == sacs_pkg::ST_ACQ && result_valid_out && !busy_out)
        else $error("No return");
    conv_len_a: assert property ($rose(busy_out) |-> busy_out [*8])
        else $error("Conversion too short");
    sat_hi_a: assert property (state_reg == sacs_pkg::ST_DONE && sat_hi_reg
        |=> result_out == sacs_pkg::CODE_MAX) else $error("No high clamp");
    sat_lo_a: assert property (state_reg == sacs_pkg::ST_DONE
        && !sat_hi_reg && sat_lo_reg
        |=> result_out == sacs_pkg::CODE_MIN) else $error("No low clamp");
    twos_code_a: assert property (state_reg == sacs_pkg::ST_DONE
        && !sat_hi_reg && !sat_lo_reg
        |=> result_out == {~$past(trial_reg[15]), $past(trial_reg[14:0])})
        else $error("Bad code");
    power_idle_a: assert property (state_reg == sacs_pkg::ST_ACQ && !cnv_rise
        |=> !powered_up_out) else $error("Powered while idle");
    no_restart_a: assert property (state_reg == sacs_pkg::ST_DECIDE && !conv_tick
        |=> state_reg == sacs_pkg::ST_DECIDE) else $error("Restarted");
    // A convert edge outside acquisition must never reopen the switches
    retrig_ignored_a: assert property (cnv_rise && state_reg != sacs_pkg::ST_ACQ
        |=> state_reg != sacs_pkg::ST_OPEN_SW) else $error("Edge restarted conversion");
    valid_pulse_a: assert property (result_valid_out |=> !result_valid_out)
        else $error("Valid not a pulse");
endmodule : sacs_sequencer

// [verilog/sacs_pkg.sv]
// Constants for the successive-approximation conversion sequencer
package sacs_pkg;
    localparam int          RES_BITS     = 16;                 // Result width in bits
    localparam logic [15:0] CODE_MAX     = 16'h7FFF;           // Over-range code
    localparam logic [15:0] CODE_MIN     = 16'h8000;           // Under-range code
    localparam logic [15:0] CODE_ZERO    = 16'h0000;           // Reset value of result
    localparam logic [3:0]  MSB_INDEX    = 4'hF;               // First bit decided
    localparam int          CLK_HZ       = 25_000_000;         // System clock rate
    localparam int          SETTLE_NS    = 40;                 // Least switch settle time
    localparam int          SETTLE_CYC_I = (SETTLE_NS * CLK_HZ / 1000 + 999_999) / 1_000_000;
    localparam logic [3:0]  SETTLE_CYC   = 4'(SETTLE_CYC_I < 1 ? 1 : SETTLE_CYC_I); // Cycles
    localparam logic [3:0]  CONV_DIV     = 4'h1;               // Conversion clock divide - 1
    typedef enum logic [2:0] {
        ST_ACQ, ST_OPEN_SW, ST_GROUND, ST_DECIDE, ST_DONE
    } sacs_state_type;
endpackage : sacs_pkg

// [bench/sacs_analog_model.sv]
// Comparator model of the capacitor arrays holding one sampled input level
`timescale 1ns/100ps
module sacs_analog_model (
    input  wire logic [15:0] dac_trial_in,   // Trial word from the sequencer
    input  wire logic [15:0] level_code_in,  // Sampled level as a two's-complement code
    output logic             comp_high_out   // High while the level is at or above the trial
);
    // Offset binary level against the binary-weighted trial; keeps the trial bit when high
    assign comp_high_out = (dac_trial_in <= (level_code_in ^ 16'h8000));
endmodule : sacs_analog_model

// [bench/sacs_sequencer_tb.sv]
// Self-checking testbench for the conversion sequencer
`timescale 1ns/100ps
module sacs_sequencer_tb;
    logic        clk_in, rst_n_in, convert_start_in, comp_high_in;  // Clock, reset, convert pin, comparator
    logic        over_range_in, under_range_in;                      // Range flags
    logic        pos_sw, neg_sw, arr_in, pwr, busy_out, valid;       // Status outputs
    logic [15:0] dac_trial, result_out, level_code;                  // Words
    int          err_count, comparisons;                             // Tallies

    sacs_sequencer DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .convert_start_in(convert_start_in), .comp_high_in(comp_high_in),
        .over_range_in(over_range_in), .under_range_in(under_range_in),
        .pos_sample_switch_out(pos_sw), .neg_sample_switch_out(neg_sw),
        .array_to_input_out(arr_in), .dac_trial_out(dac_trial), .powered_up_out(pwr),
        .busy_out(busy_out), .result_valid_out(valid), .result_out(result_out));
    sacs_analog_model ANA (.dac_trial_in(dac_trial), .level_code_in(level_code),
        .comp_high_out(comp_high_in));

    // Clock generator, 40 ns period
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    // Compare one value and count it
    task check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Print tallies and verdict, then stop
    task tally_and_finish;
        $display("Comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    // Bounded wait for busy to reach a level
    task wait_busy(input logic lvl);
        int n;
        for (n = 0; n < 80; n++) begin
            @(negedge clk_in);
            if (busy_out === lvl) return;
        end
        err_count++;
        $display("ERROR t=%0t got=%h exp=%h", $time, busy_out, lvl);
        tally_and_finish();
    endtask : wait_busy

    // Reset for six cycles and check idle outputs
    task reset_scenario;
        rst_n_in = 1'b0;
        repeat (6) @(negedge clk_in);
        check({11'h000, pos_sw, neg_sw, arr_in, pwr, busy_out}, 16'h001C);
        check({15'h0000, valid}, 16'h0000);
        check(result_out, 16'h0000);
        rst_n_in = 1'b1;
    endtask : reset_scenario

    // One conversion; optional new convert edge while it runs
    task run_conv(input logic [15:0] code, input logic ov, input logic un,
                  input logic retrig, input logic [15:0] exp);
        level_code       = code;
        over_range_in    = ov;
        under_range_in   = un;
        convert_start_in = 1'b1;
        wait_busy(1'b1);
        repeat (2) @(negedge clk_in);
        check({12'h000, pos_sw, neg_sw, arr_in, pwr}, 16'h0001);
        check(dac_trial, 16'h8000);
        if (retrig) begin
            convert_start_in = 1'b0;
            repeat (4) @(negedge clk_in);
            convert_start_in = 1'b1;
        end
        wait_busy(1'b0);
        check({15'h0000, valid}, 16'h0001);
        check(result_out, exp);
        @(negedge clk_in);
        // Switches close and arrays reconnect one cycle after busy falls
        check({12'h000, pos_sw, neg_sw, arr_in, pwr}, 16'h000E);
        check({15'h0000, valid}, 16'h0000);
        convert_start_in = 1'b0;
        repeat (12) begin
            @(negedge clk_in);
            check({15'h0000, busy_out}, 16'h0000);
        end
    endtask : run_conv

    // Main sequence
    initial begin
        err_count = 0;
        comparisons = 0;
        convert_start_in = 1'b0;
        over_range_in = 1'b0;
        under_range_in = 1'b0;
        level_code = 16'h0000;
        rst_n_in = 1'b0;
        @(negedge clk_in);
        reset_scenario();
        run_conv(16'h0000, 1'b0, 1'b0, 1'b0, 16'h0000);
        run_conv(16'h0001, 1'b0, 1'b0, 1'b1, 16'h0001);
        run_conv(16'hFFFF, 1'b0, 1'b0, 1'b0, 16'hFFFF);
        run_conv(16'h8001, 1'b0, 1'b0, 1'b0, 16'h8001);
        run_conv(16'h7FFF, 1'b0, 1'b0, 1'b0, 16'h7FFF);
        run_conv(16'h8000, 1'b0, 1'b0, 1'b0, 16'h8000);
        run_conv(16'h1234, 1'b1, 1'b0, 1'b0, 16'h7FFF);
        run_conv(16'h1234, 1'b0, 1'b1, 1'b0, 16'h8000);
        run_conv(16'hA5C3, 1'b1, 1'b1, 1'b1, 16'h7FFF);
        tally_and_finish();
    end
endmodule : sacs_sequencer_tb
